/* File: power_sequencing_fault_retry.sv */
`timescale 1ns/1ps
module power_sequencing_fault_retry #(
   parameter int unsigned MS_CYCLES = pseq_pkg::MS_CYCLES
) (
   input wire logic clock, // 125 MHz clock
   input wire logic rst_n, // async reset
   input wire logic ce, // clock enable
   input wire logic cmd_valid, // command strobe
   input wire pseq_pkg::cmd_s cmd, // command code and data
   output logic rd_valid, // read data strobe
   output logic [15:0] rd_data, // read data
   input wire logic enable_pin, // turn-on request pin
   input wire logic clear_faults, // clear latched fault pulse
   input wire logic [15:0] vout, // measured output voltage
   input wire logic [15:0] vout_uv_limit, // output undervoltage limit
   output logic output_enable, // power stage on
   output logic ramp_active, // output ramping up
   output logic power_good_indication, // output in regulation
   output logic fault_latched, // output off until cleared
   output logic [2:0] retry_count // restarts made so far; not counted in continuous retry
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [15:0] pgood_assert_threshold;
   logic [15:0] pgood_deassert_threshold;
   logic [15:0] turn_on_delay;
   logic [15:0] turn_on_ramp_time;
   logic [15:0] turn_on_timeout_limit;
   logic [7:0] fault_response;
   logic [15:0] delay_time_unit;
   logic [15:0] next_pg_on, next_pg_off, next_delay, next_ramp;
   logic [15:0] next_limit, next_unit, next_rd_data;
   logic [7:0] next_resp;
   logic next_rd_valid;

   always_comb begin
      next_pg_on = pgood_assert_threshold;
      next_pg_off = pgood_deassert_threshold;
      next_delay = turn_on_delay;
      next_ramp = turn_on_ramp_time;
      next_limit = turn_on_timeout_limit;
      next_resp = fault_response;
      next_unit = delay_time_unit;
      next_rd_valid = cmd_valid && !cmd.write;
      next_rd_data = pseq_pkg::READ_UNMAPPED;
      if (cmd_valid && cmd.write) begin
         if (cmd.code == pseq_pkg::CODE_PG_ASSERT) begin
            next_pg_on = cmd.data;
         end else if (cmd.code == pseq_pkg::CODE_PG_DEASSERT) begin
            next_pg_off = cmd.data;
         end else if (cmd.code == pseq_pkg::CODE_TURN_ON_DELAY) begin
            next_delay = cmd.data;
         end else if (cmd.code == pseq_pkg::CODE_TON_RAMP) begin
            next_ramp = cmd.data;
         end else if (cmd.code == pseq_pkg::CODE_TON_LIMIT) begin
            next_limit = cmd.data;
         end else if (cmd.code == pseq_pkg::CODE_FAULT_RESP) begin
            next_resp = cmd.data[7:0];
         end else if (cmd.code == pseq_pkg::CODE_TIME_UNIT) begin
            next_unit = cmd.data;
         end
      end else if (cmd_valid) begin
         if (cmd.code == pseq_pkg::CODE_PG_ASSERT) begin
            next_rd_data = pgood_assert_threshold;
         end else if (cmd.code == pseq_pkg::CODE_PG_DEASSERT) begin
            next_rd_data = pgood_deassert_threshold;
         end else if (cmd.code == pseq_pkg::CODE_TURN_ON_DELAY) begin
            next_rd_data = turn_on_delay;
         end else if (cmd.code == pseq_pkg::CODE_TON_RAMP) begin
            next_rd_data = turn_on_ramp_time;
         end else if (cmd.code == pseq_pkg::CODE_TON_LIMIT) begin
            next_rd_data = turn_on_timeout_limit;
         end else if (cmd.code == pseq_pkg::CODE_FAULT_RESP) begin
            next_rd_data = {8'h00, fault_response};
         end else if (cmd.code == pseq_pkg::CODE_TIME_UNIT) begin
            next_rd_data = delay_time_unit;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pgood_assert_threshold <= pseq_pkg::RST_THRESHOLD;
         pgood_deassert_threshold <= pseq_pkg::RST_THRESHOLD;
         turn_on_delay <= pseq_pkg::RST_TIMING;
         turn_on_ramp_time <= pseq_pkg::RST_TIMING;
         turn_on_timeout_limit <= pseq_pkg::RST_TIMING;
         fault_response <= pseq_pkg::RST_FAULT_RESP;
         delay_time_unit <= pseq_pkg::RST_TIME_UNIT;
         rd_valid <= 1'b0;
         rd_data <= pseq_pkg::READ_UNMAPPED;
      end else if (ce) begin
         pgood_assert_threshold <= next_pg_on;
         pgood_deassert_threshold <= next_pg_off;
         turn_on_delay <= next_delay;
         turn_on_ramp_time <= next_ramp;
         turn_on_timeout_limit <= next_limit;
         fault_response <= next_resp;
         delay_time_unit <= next_unit;
         rd_valid <= next_rd_valid;
         rd_data <= next_rd_data;
      end
   end

   // ----------------------------------------------------------------
   // time base and decoded times
   // ----------------------------------------------------------------
   logic [31:0] presc;
   logic [31:0] next_presc;
   logic tick;
   logic en_meta, en_sync;
   logic [pseq_pkg::TIME_W-1:0] delay_ms, ramp_ms, limit_ms, interval_ms;
   logic [1:0] resp;
   logic [2:0] retries;

   assign tick = ce && presc == MS_CYCLES - 1;
   assign next_presc = (presc >= MS_CYCLES - 1) ? 32'h00000000 : presc + 1;
   assign resp = fault_response[pseq_pkg::RESP_HI:pseq_pkg::RESP_LO];
   assign retries = fault_response[pseq_pkg::RETRY_HI:pseq_pkg::RETRY_LO];
   // unit count shifted by the delay code
   assign interval_ms = {8'h00, delay_time_unit} << fault_response[
      pseq_pkg::DELAY_HI:pseq_pkg::DELAY_LO];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         presc <= '0;
         en_meta <= 1'b0;
         en_sync <= 1'b0;
      end else if (ce) begin
         presc <= next_presc;
         en_meta <= enable_pin;
         en_sync <= en_meta;
      end
   end

   linear_to_ms u_delay_dec (.clock(clock), .rst_n(rst_n), .ce(ce),
      .lin(turn_on_delay), .ms(delay_ms));
   linear_to_ms u_ramp_dec (.clock(clock), .rst_n(rst_n), .ce(ce),
      .lin(turn_on_ramp_time), .ms(ramp_ms));
   linear_to_ms u_limit_dec (.clock(clock), .rst_n(rst_n), .ce(ce),
      .lin(turn_on_timeout_limit), .ms(limit_ms));

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   pseq_pkg::seq_state_e state, next_state;
   logic [pseq_pkg::TIME_W-1:0] attempt_ms, next_attempt_ms, seq_value;
   logic [2:0] next_retry_cnt;
   logic reached, next_reached, out_on, ton_fault, retry_now;
   logic seq_load, max_load, tmr_stop, seq_done, max_done;
   logic next_out_en, next_latched;

   assign out_on = state == pseq_pkg::SEQ_RAMP ||
      state == pseq_pkg::SEQ_ON || state == pseq_pkg::SEQ_RUN_ON;
   // zero limit also masks a timer armed before the limit was cleared
   assign ton_fault = max_done && !reached && limit_ms != '0 &&
      (state == pseq_pkg::SEQ_RAMP ||
      state == pseq_pkg::SEQ_ON);

   always_comb begin
      next_state = state;
      next_retry_cnt = retry_count;
      next_attempt_ms = attempt_ms;
      next_reached = reached;
      seq_load = 1'b0;
      seq_value = delay_ms;
      max_load = 1'b0;
      retry_now = 1'b0;
      if (tick && attempt_ms != pseq_pkg::TIME_MAX) begin
         next_attempt_ms = attempt_ms + 1'b1;
      end
      if (out_on && vout >= vout_uv_limit) begin
         next_reached = 1'b1;
      end
      case (state)
         pseq_pkg::SEQ_OFF: begin
            if (en_sync) begin
               next_state = pseq_pkg::SEQ_DELAY;
               seq_load = 1'b1;
               next_attempt_ms = '0;
               next_reached = 1'b0;
               next_retry_cnt = '0;
            end
         end
         pseq_pkg::SEQ_DELAY: begin
            if (seq_done) begin
               next_state = pseq_pkg::SEQ_RAMP;
               seq_load = 1'b1;
               seq_value = ramp_ms;
               max_load = limit_ms != '0;
            end
         end
         pseq_pkg::SEQ_RAMP: begin
            if (seq_done) begin
               next_state = pseq_pkg::SEQ_ON;
            end
         end
         pseq_pkg::SEQ_RUN_ON: begin
            if (seq_done && !reached) begin
               retry_now = 1'b1;
            end else if (seq_done) begin
               next_state = pseq_pkg::SEQ_ON;
            end
         end
         pseq_pkg::SEQ_RETRY_WAIT: begin
            if (attempt_ms >= interval_ms) begin
               next_state = pseq_pkg::SEQ_DELAY;
               seq_load = 1'b1;
               next_attempt_ms = '0;
               next_reached = 1'b0;
            end
         end
         pseq_pkg::SEQ_LATCHED: begin
            if (clear_faults) begin
               next_state = pseq_pkg::SEQ_OFF;
            end
         end
         default: begin
         end
      endcase
      if (ton_fault) begin
         case (resp)
            pseq_pkg::RESP_RUN_ON: begin
               next_state = pseq_pkg::SEQ_RUN_ON;
               seq_load = 1'b1;
               seq_value = interval_ms;
            end
            pseq_pkg::RESP_RETRY: retry_now = 1'b1;
            pseq_pkg::RESP_LATCH: next_state = pseq_pkg::SEQ_LATCHED;
            default: begin
            end
         endcase
      end
      if (retry_now) begin
         if (retries == pseq_pkg::RETRY_NONE ||
               (retries != pseq_pkg::RETRY_FOREVER &&
               retry_count >= retries)) begin
            next_state = pseq_pkg::SEQ_LATCHED;
         end else begin
            next_state = pseq_pkg::SEQ_RETRY_WAIT;
            if (retries != pseq_pkg::RETRY_FOREVER) begin
               next_retry_cnt = retry_count + 1'b1;
            end
         end
      end
      // commanded off ends any retry run and clears the latch
      if (!en_sync) begin
         next_state = pseq_pkg::SEQ_OFF;
      end
      tmr_stop = next_state == pseq_pkg::SEQ_OFF ||
         next_state == pseq_pkg::SEQ_LATCHED ||
         next_state == pseq_pkg::SEQ_RETRY_WAIT;
      next_out_en = next_state == pseq_pkg::SEQ_RAMP ||
         next_state == pseq_pkg::SEQ_ON || next_state == pseq_pkg::SEQ_RUN_ON;
      next_latched = next_state == pseq_pkg::SEQ_LATCHED;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= pseq_pkg::SEQ_OFF;
         retry_count <= '0;
         attempt_ms <= '0;
         reached <= 1'b0;
         output_enable <= 1'b0;
         ramp_active <= 1'b0;
         fault_latched <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         retry_count <= next_retry_cnt;
         attempt_ms <= next_attempt_ms;
         reached <= next_reached;
         output_enable <= next_out_en;
         ramp_active <= next_state == pseq_pkg::SEQ_RAMP;
         fault_latched <= next_latched;
      end
   end

   ms_timer u_seq_tmr (.clock(clock), .rst_n(rst_n), .ce(ce), .tick(tick),
      .load(seq_load), .stop(tmr_stop), .value(seq_value), .done(seq_done));
   ms_timer u_max_tmr (.clock(clock), .rst_n(rst_n), .ce(ce), .tick(tick),
      .load(max_load), .stop(tmr_stop), .value(limit_ms), .done(max_done));

   // ----------------------------------------------------------------
   // power good with hysteresis
   // ----------------------------------------------------------------
   logic next_pg;

   always_comb begin
      next_pg = power_good_indication;
      if (!next_out_en) begin
         next_pg = 1'b0;
      end else if (vout >= pgood_assert_threshold) begin
         next_pg = 1'b1;
      end else if (vout < pgood_deassert_threshold) begin
         next_pg = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         power_good_indication <= 1'b0;
      end else if (ce) begin
         power_good_indication <= next_pg;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_latch_keeps_off: assert property (
      fault_latched |-> !output_enable)
      else $error("output on while fault latched");
   a_retry_count_bound: assert property (
      state == pseq_pkg::SEQ_RETRY_WAIT && retries != pseq_pkg::RETRY_FOREVER
      |-> retry_count <= retries && retry_count != 3'h0)
      else $error("retry count beyond setting");
   a_forever_no_latch: assert property (
      ce && en_sync && retry_now && retries == pseq_pkg::RETRY_FOREVER
      |=> state == pseq_pkg::SEQ_RETRY_WAIT)
      else $error("continuous retry stopped");
   a_retry_spacing: assert property (
      state == pseq_pkg::SEQ_RETRY_WAIT ##1 state == pseq_pkg::SEQ_DELAY
      |-> $past(attempt_ms) >= $past(interval_ms))
      else $error("restart came too early");
   a_no_limit_fault: assert property (
      state == pseq_pkg::SEQ_ON && limit_ms == '0
      |=> state == pseq_pkg::SEQ_ON || state == pseq_pkg::SEQ_OFF)
      else $error("timeout with zero limit");
   a_timeout_response: assert property (
      ce && en_sync && ton_fault && resp == pseq_pkg::RESP_LATCH
      |=> fault_latched && !output_enable)
      else $error("timeout not handled");
   a_pg_rise_level: assert property (
      $rose(power_good_indication)
      |-> $past(vout) >= $past(pgood_assert_threshold))
      else $error("power good rose below threshold");
   a_pg_fall_level: assert property (
      $fell(power_good_indication) |-> $past(vout) <
      $past(pgood_deassert_threshold) || !output_enable)
      else $error("power good fell above threshold");
   a_ramp_after_delay: assert property (
      $rose(ramp_active) |-> $past(state) == pseq_pkg::SEQ_DELAY)
      else $error("ramp without turn-on delay");
   a_readback_assert: assert property (
      ce && cmd_valid && !cmd.write && cmd.code == pseq_pkg::CODE_PG_ASSERT
      |=> rd_valid && rd_data == $past(pgood_assert_threshold))
      else $error("assert threshold readback wrong");
endmodule

/* File: pseq_pkg.sv */
package pseq_pkg;

   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CODE_PG_ASSERT = 8'h5E;
   localparam logic [7:0] CODE_PG_DEASSERT = 8'h5F;
   localparam logic [7:0] CODE_TURN_ON_DELAY = 8'h60;
   localparam logic [7:0] CODE_TON_RAMP = 8'h61;
   localparam logic [7:0] CODE_TON_LIMIT = 8'h62;
   localparam logic [7:0] CODE_FAULT_RESP = 8'h63;
   localparam logic [7:0] CODE_TIME_UNIT = 8'hC8;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_THRESHOLD = 16'h0000;
   localparam logic [15:0] RST_TIMING = 16'h0000;
   localparam logic [7:0] RST_FAULT_RESP = 8'hC0;
   localparam logic [15:0] RST_TIME_UNIT = 16'h0001;
   localparam logic [15:0] READ_UNMAPPED = 16'h0000;

   // ----------------------------------------------------------------
   // fault response fields and codes
   // ----------------------------------------------------------------
   localparam int RESP_HI = 7;
   localparam int RESP_LO = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DELAY_HI = 2;
   localparam int DELAY_LO = 0;
   localparam logic [1:0] RESP_IGNORE = 2'h0;
   localparam logic [1:0] RESP_RUN_ON = 2'h1;
   localparam logic [1:0] RESP_RETRY = 2'h2;
   localparam logic [1:0] RESP_LATCH = 2'h3;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;

   // ----------------------------------------------------------------
   // linear format fields
   // ----------------------------------------------------------------
   localparam int LIN_EXP_HI = 15;
   localparam int LIN_EXP_LO = 11;
   localparam int LIN_MANT_HI = 10;
   localparam int LIN_MANT_LO = 0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int TIME_W = 24;
   localparam logic [TIME_W-1:0] TIME_MAX = 24'hFFFFFF;
   localparam int unsigned CLOCK_HZ = 125_000_000;
   localparam int unsigned TICK_TIME_MS = 1;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned MS_CYCLES = CLOCK_HZ / MS_PER_S * TICK_TIME_MS;

   typedef struct packed {
      logic write;
      logic [7:0] code;
      logic [15:0] data;
   } cmd_s;

   typedef enum logic [2:0] {
      SEQ_OFF,
      SEQ_DELAY,
      SEQ_RAMP,
      SEQ_ON,
      SEQ_RUN_ON,
      SEQ_RETRY_WAIT,
      SEQ_LATCHED
   } seq_state_e;

endpackage

/* File: ms_timer.sv */
`timescale 1ns/1ps
module ms_timer (
   input wire logic clock, // system clock
   input wire logic rst_n, // async reset
   input wire logic ce, // clock enable
   input wire logic tick, // one ms tick
   input wire logic load, // start countdown
   input wire logic stop, // cancel countdown
   input wire logic [pseq_pkg::TIME_W-1:0] value, // ms to count
   output logic done // one-cycle expiry pulse
);
   logic [pseq_pkg::TIME_W-1:0] count;
   logic [pseq_pkg::TIME_W-1:0] next_count;
   logic armed;
   logic next_armed;
   logic next_done;

   always_comb begin
      next_count = count;
      next_armed = armed;
      next_done = 1'b0;
      if (load) begin
         next_count = value;
         next_armed = 1'b1;
      end else if (stop) begin
         next_armed = 1'b0;
      end else if (armed && count == '0) begin
         next_armed = 1'b0;
         next_done = 1'b1;
      end else if (armed && tick) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         armed <= 1'b0;
         done <= 1'b0;
      end else if (ce) begin
         count <= next_count;
         armed <= next_armed;
         done <= next_done;
      end
   end
endmodule

/* File: linear_to_ms.sv */
`timescale 1ns/1ps
module linear_to_ms (
   input wire logic clock, // system clock
   input wire logic rst_n, // async reset
   input wire logic ce, // clock enable
   input wire logic [15:0] lin, // linear format value
   output logic [pseq_pkg::TIME_W-1:0] ms // whole milliseconds
);
   logic signed [4:0] expo;
   logic [10:0] mant;
   logic [4:0] shift;
   logic [31:0] wide;
   logic [pseq_pkg::TIME_W-1:0] next_ms;

   assign expo = lin[pseq_pkg::LIN_EXP_HI:pseq_pkg::LIN_EXP_LO];
   assign mant = lin[pseq_pkg::LIN_MANT_HI:pseq_pkg::LIN_MANT_LO];

   // negative mantissa means no time; large values saturate
   always_comb begin
      shift = 5'(-expo);
      wide = '0;
      if (!mant[10]) begin
         if (expo >= 0) begin
            wide = {22'h0, mant[9:0]} << 5'(expo);
         end else begin
            wide = {22'h0, mant[9:0]} >> shift;
         end
      end
      if (wide > {8'h00, pseq_pkg::TIME_MAX}) begin
         next_ms = pseq_pkg::TIME_MAX;
      end else begin
         next_ms = wide[pseq_pkg::TIME_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ms <= '0;
      end else if (ce) begin
         ms <= next_ms;
      end
   end
endmodule

/* File: pmbus_host.sv */
`timescale 1ns/1ps
module pmbus_host (
   output logic cmd_valid, // command strobe
   output pseq_pkg::cmd_s cmd, // command word
   input wire logic clock // system clock
);
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end
   // one-cycle command, fields scrambled when idle
   task automatic send(input logic wr, input logic [7:0] code,
         input logic [15:0] data);
      @(negedge clock);
      cmd_valid = 1'b1;
      cmd = '{write: wr, code: code, data: data};
      @(negedge clock);
      cmd_valid = 1'b0;
      cmd = ~cmd;
   endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic en = 1'b0;
   logic clr = 1'b0;
   logic ce = 1'b1;
   logic [15:0] vout = 16'h1000;
   logic [15:0] uv = 16'h2000;
   logic cmd_valid, rd_valid, oe, ramp, pg, latched;
   pseq_pkg::cmd_s cmd;
   logic [15:0] rd_data;
   logic [2:0] retry_count;
   logic [15:0] exp_q[$];
   logic [31:0] seed = 32'h685A;
   logic [15:0] v;
   int mismatches = 0;
   int n_compared = 0;
   int i, n, last;
   always #4 clock = ~clock;
   pmbus_host host (.cmd_valid(cmd_valid), .cmd(cmd), .clock(clock));
   power_sequencing_fault_retry #(.MS_CYCLES(4)) DUT (
      .clock(clock), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid),
      .cmd(cmd), .rd_valid(rd_valid), .rd_data(rd_data),
      .enable_pin(en), .clear_faults(clr), .vout(vout),
      .vout_uv_limit(uv), .output_enable(oe), .ramp_active(ramp),
      .power_good_indication(pg), .fault_latched(latched),
      .retry_count(retry_count));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   task automatic chk(string name, logic [15:0] e, logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", name, e, g);
         mismatches++;
      end
   endtask
   task automatic end_of_test();
      if (exp_q.size() != 0) mismatches++;
      if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic rd(logic [7:0] code, logic [15:0] e);
      exp_q.push_back(e);
      host.send(1'b0, code, 16'h0000);
   endtask
   task automatic wr(logic [7:0] code, logic [15:0] d);
      host.send(1'b1, code, d);
   endtask
   always @(negedge clock) if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("rd_extra", 16'h0000, 16'hFFFF);
      else chk("rd_data", exp_q.pop_front(), rd_data);
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      for (int k = 0; k < 5; k++) rd(8'(8'h5E + k), 16'h0000);
      rd(8'h63, 16'h00C0);
      rd(8'h00, 16'h0000);
      for (int k = 0; k < 5; k++) begin
         v = xs();
         wr(8'(8'h5E + k), v);
         rd(8'(8'h5E + k), v);
      end
      wr(8'h00, xs());
      rd(8'h00, 16'h0000);
      wr(8'hC8, 16'h0002);
      rd(8'hC8, 16'h0002);
      wr(8'h60, 16'h0001);
      wr(8'h61, 16'h0001);
      wr(8'h62, 16'h0000);
      wr(8'h5E, 16'h1000);
      wr(8'h5F, 16'h0C00);
      ce = 1'b0;
      wr(8'h5F, 16'h5555);
      ce = 1'b1;
      rd(8'h5F, 16'h0C00);
      wr(8'h63, 16'h00A3);
      en = 1'b1;
      for (i = 0; i < 50 && ramp !== 1'b1; i++) @(negedge clock);
      for (i = 0; i < 50 && ramp === 1'b1; i++) @(negedge clock);
      chk("ramp_len", 16'h0001, 16'(i >= 3 && i <= 6));
      repeat (200) @(negedge clock);
      chk("no_limit", 16'h0000, 16'(latched));
      chk("pg_on", 16'h0001, 16'(pg));
      vout = 16'h0E00;
      repeat (4) @(negedge clock);
      chk("pg_hold", 16'h0001, 16'(pg));
      vout = 16'h0BFF;
      repeat (4) @(negedge clock);
      chk("pg_off", 16'h0000, 16'(pg));
      en = 1'b0;
      wr(8'h62, 16'h0002);
      repeat (8) @(negedge clock);
      en = 1'b1;
      count_on(2000, 1'b1);
      chk("attempts", 16'd5, 16'(n));
      chk("retries", 16'd4, 16'(retry_count));
      chk("latched", 16'h0001, 16'(latched));
      repeat (100) @(negedge clock);
      chk("stays_off", 16'h0000, 16'(oe));
      clr = 1'b1;
      @(negedge clock);
      clr = 1'b0;
      repeat (4) @(negedge clock);
      chk("cleared", 16'h0000, 16'(latched));
      en = 1'b0;
      wr(8'h63, 16'h00C3);
      repeat (8) @(negedge clock);
      en = 1'b1;
      count_on(300, 1'b1);
      chk("latch_n", 16'd1, 16'(n));
      chk("latch_fast", 16'h0001, 16'(i < 40));
      en = 1'b0;
      wr(8'h63, 16'h0043);
      repeat (8) @(negedge clock);
      en = 1'b1;
      count_on(300, 1'b1);
      chk("run_on_n", 16'd1, 16'(n));
      chk("run_on_late", 16'h0001, 16'(i > 64));
      en = 1'b0;
      wr(8'h63, 16'h00BB);
      repeat (8) @(negedge clock);
      en = 1'b1;
      count_on(700, 1'b0);
      chk("endless", 16'h0001, 16'(n >= 8 && latched === 1'b0));
      chk("uncounted", 16'h0000, 16'(retry_count));
      en = 1'b0;
      repeat (6) @(negedge clock);
      chk("off", 16'h0000, 16'(oe));
      end_of_test();
   end
   // counts turn-ons; spacing is unit shifted left by delay code, 64 cycles
   task automatic count_on(int cyc, logic stop_on_latch);
      logic prev;
      prev = oe;
      n = 0;
      last = 0;
      for (i = 0; i < cyc && !(stop_on_latch && latched === 1'b1);
            i++) begin
         @(negedge clock);
         if (oe === 1'b1 && prev !== 1'b1) begin
            if (n > 0) chk("spacing", 16'h0001,
                  16'(i - last >= 60 && i - last <= 68));
            n++;
            last = i;
         end
         prev = oe;
      end
      if (stop_on_latch && i == cyc) begin
         mismatches++;
         end_of_test();
      end
   endtask
endmodule
